// >>> bench/vector_fp_csr_unit_tb_top.sv
// self-checking testbench for the vector floating-point control/status unit
// assumes the unit's default parameters, so the denormal mode is supported
`timescale 1ns/1ps
`default_nettype none
module vector_fp_csr_unit_tb_top;
	import vfp_pkg::*;
	logic clock = 1'b0;
	logic rst_n, soft_init_in, op_valid, op_supported, legacy_error_pending_in;
	logic ignore_numeric_error_in, fp_error_out, vreg_wr_en, flush_zero_mode, denormals_zero_mode;
	logic vector_fp_fault, invalid_opcode_fault, general_protection_fault;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, csr_exp, sys_exp, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rounding_mode, rsp;
	logic [NUM_LANES*NUM_EXC-1:0] op_lane_flags;
	logic [VREG_IDX_W-1:0] vreg_wr_idx, vreg_rd_idx;
	logic [VREG_W-1:0] vreg_wr_data, vreg_rd_data, vdat;
	int fail_count = 0;
	int n_tests = 0;
	int vec_n = 0, opc_n = 0, prot_n = 0, vec_e = 0, opc_e = 0, prot_e = 0;

	vector_fp_csr_unit DUT (.clock(clock), .rst_n(rst_n), .soft_init_in(soft_init_in),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .op_valid(op_valid),
		.op_supported(op_supported), .op_lane_flags(op_lane_flags),
		.vector_fp_fault(vector_fp_fault), .invalid_opcode_fault(invalid_opcode_fault),
		.general_protection_fault(general_protection_fault), .rounding_mode(rounding_mode),
		.flush_zero_mode(flush_zero_mode), .denormals_zero_mode(denormals_zero_mode),
		.legacy_error_pending_in(legacy_error_pending_in),
		.ignore_numeric_error_in(ignore_numeric_error_in), .fp_error_out(fp_error_out),
		.vreg_wr_en(vreg_wr_en), .vreg_wr_idx(vreg_wr_idx), .vreg_wr_data(vreg_wr_data),
		.vreg_rd_idx(vreg_rd_idx), .vreg_rd_data(vreg_rd_data));

	always #2 clock = ~clock;

	// --------------------------------
	// fault pulse counters
	// --------------------------------
	always @(posedge clock) begin
		if (vector_fp_fault === 1'b1)
			vec_n++;
		if (invalid_opcode_fault === 1'b1)
			opc_n++;
		if (general_protection_fault === 1'b1)
			prot_n++;
	end

	// --------------------------------
	// checking and closing
	// --------------------------------
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	task automatic check_faults();
		check(128'(vec_n), 128'(vec_e));
		check(128'(opc_n), 128'(opc_e));
		check(128'(prot_n), 128'(prot_e));
	endtask

	task automatic timed_out();
		fail_count++;
		wrap_up();
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	// --------------------------------
	// bus master, entered just after a rising edge
	// --------------------------------
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int i;
		logic aw, w, done;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		done = 1'b0;
		for (i = 0; i < 100 && !done; i++) begin
			@(negedge clock);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			done = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clock);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end
		if (!done)
			timed_out();
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		logic ar, done;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		done = 1'b0;
		for (i = 0; i < 100 && !done; i++) begin
			@(negedge clock);
			ar = s_axi_arvalid & s_axi_arready;
			done = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clock);
			if (ar)
				s_axi_arvalid <= 1'b0;
		end
		if (!done)
			timed_out();
	endtask

	// --------------------------------
	// expectation helpers
	// --------------------------------
	function automatic logic [5:0] merge(input logic [23:0] f);
		merge = f[5:0] | f[11:6] | f[17:12] | f[23:18];
	endfunction

	task automatic csr_wr(input logic [31:0] d);
		axi_write(OFS_CSR, d, rsp);
		if ((d & ~CSR_MASK_FULL) != 32'h0) begin
			check(128'(rsp), 128'(RESP_SLVERR));
			prot_e++;
		end else begin
			check(128'(rsp), 128'(RESP_OKAY));
			csr_exp = d;
		end
		tick(2);
		axi_read(OFS_CSR, rd, rsp);
		check(128'(rd), 128'(csr_exp));
		check_faults();
	endtask

	task automatic sys_wr(input logic [31:0] d);
		axi_write(OFS_SYS_CTRL, d, rsp);
		sys_exp = d;
		check(128'(rsp), 128'(RESP_OKAY));
	endtask

	task automatic run_op(input logic [23:0] f, input logic s);
		logic [5:0] open;
		op_lane_flags <= f;
		op_supported <= s;
		op_valid <= 1'b1;
		@(posedge clock);
		op_valid <= 1'b0;
		open = merge(f) & ~csr_exp[12:7];
		if (!s)
			opc_e++;
		else begin
			csr_exp[5:0] = csr_exp[5:0] | merge(f);
			if (open != 6'h0 && sys_exp[OS_SIMD_BIT])
				vec_e++;
			else if (open != 6'h0)
				opc_e++;
		end
		tick(2);
	endtask

	task automatic vreg_check(input int n);
		for (int i = 0; i < n; i++) begin
			vreg_rd_idx <= 3'(i);
			tick(2);
			check(vreg_rd_data, 128'h0);
		end
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		timed_out();
	end

	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		rst_n = 1'b0;
		{soft_init_in, op_valid, op_supported, legacy_error_pending_in} = 4'h0;
		{ignore_numeric_error_in, vreg_wr_en, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, op_lane_flags} = '0;
		{vreg_wr_idx, vreg_rd_idx, vreg_wr_data} = '0;
		{csr_exp, sys_exp} = {CSR_RESET, 32'h0};
		void'($urandom(45253));
		tick(5);
		rst_n <= 1'b1;
		tick(1);
		axi_read(OFS_CSR, rd, rsp);
		check(128'(rd), 128'(CSR_RESET));
		check(128'({rounding_mode, flush_zero_mode, denormals_zero_mode}), 128'h0);
		axi_read(OFS_SAVED_MASK, rd, rsp);
		check(128'(rd), 128'(CSR_MASK_FULL));
		axi_read(OFS_IDENTIFY, rd, rsp);
		check(128'(rd & 32'h0700_0000), 128'h0700_0000);
		vreg_check(NUM_VREGS);
		axi_read(8'h14, rd, rsp);
		check(128'({rd, rsp}), 128'({32'h0, RESP_SLVERR}));
		axi_write(OFS_IDENTIFY, 32'hFFFF_FFFF, rsp);
		check(128'(rsp), 128'(RESP_SLVERR));
		for (int m = 0; m < 4; m++) begin
			csr_wr(CSR_RESET | 32'(m << ROUND_LSB) | 32'(($urandom % 2) << FTZ_BIT)
				| 32'(($urandom % 2) << DENORM_ZERO_BIT));
			check(128'({rounding_mode, flush_zero_mode, denormals_zero_mode}),
				128'({csr_exp[14:13], csr_exp[FTZ_BIT], csr_exp[DENORM_ZERO_BIT]}));
		end
		csr_wr(csr_exp | (32'h1 << (16 + $urandom % 16)));
		csr_wr(CSR_RESET);
		for (int k = 0; k < 20; k++)
			run_op(24'($urandom) & 24'($urandom), 1'b1);
		run_op(24'h0, 1'b1);
		run_op(24'hFF_FFFF, 1'b0);
		axi_read(OFS_CSR, rd, rsp);
		check(128'(rd), 128'(csr_exp));
		csr_wr(32'h0000_003F);
		run_op(24'h00_0001, 1'b1);
		check_faults();
		sys_wr(32'h0000_0420);
		axi_read(OFS_SYS_CTRL, rd, rsp);
		check(128'(rd), 128'h420);
		run_op(24'h04_0000, 1'b1);
		ignore_numeric_error_in <= 1'b1;
		run_op(24'h00_0010, 1'b1);
		ignore_numeric_error_in <= 1'b0;
		run_op(24'h00_0800, 1'b1);
		check_faults();
		check(128'(fp_error_out), 128'h0);
		sys_wr(32'h0000_0400);
		legacy_error_pending_in <= 1'b1;
		tick(3);
		check(128'(fp_error_out), 128'h1);
		ignore_numeric_error_in <= 1'b1;
		tick(3);
		check(128'(fp_error_out), 128'h0);
		legacy_error_pending_in <= 1'b0;
		check_faults();
		axi_read(OFS_FAULT, rd, rsp);
		check(128'(rd), 128'h7);
		axi_write(OFS_FAULT, 32'h1 << FLT_VEC_BIT, rsp);
		check(128'(rsp), 128'(RESP_OKAY));
		axi_read(OFS_FAULT, rd, rsp);
		check(128'(rd), 128'h7 ^ (128'h1 << FLT_VEC_BIT));
		vdat = {$urandom, $urandom, $urandom, $urandom};
		vreg_wr_idx <= 3'h3;
		vreg_wr_data <= vdat;
		vreg_wr_en <= 1'b1;
		tick(1);
		vreg_wr_en <= 1'b0;
		soft_init_in <= 1'b1;
		tick(2);
		soft_init_in <= 1'b0;
		vreg_rd_idx <= 3'h3;
		tick(2);
		check(vreg_rd_data, vdat);
		axi_read(OFS_CSR, rd, rsp);
		check(128'(rd), 128'(csr_exp));
		axi_read(OFS_FAULT, rd, rsp);
		check(128'(rd), 128'h0);
		rst_n <= 1'b0;
		tick(5);
		rst_n <= 1'b1;
		tick(1);
		axi_read(OFS_CSR, rd, rsp);
		check(128'(rd), 128'(CSR_RESET));
		vreg_check(4);
		wrap_up();
	end
endmodule
`default_nettype wire

// >>> verilog/lane_flag_merge.sv
// ORs the per-lane exception conditions of a packed operation
// assumes lane k occupies bits [k*NUM_EXC +: NUM_EXC] of the input
`timescale 1ns/1ps
`default_nettype none
module lane_flag_merge
	import vfp_pkg::*;
(
	input wire logic [NUM_LANES*NUM_EXC-1:0] lane_flags,
	output logic [NUM_EXC-1:0] merged
);
	for (genvar b = 0; b < NUM_EXC; b++) begin : g_bit
		logic [NUM_LANES-1:0] column;
		for (genvar k = 0; k < NUM_LANES; k++) begin : g_lane
			assign column[k] = lane_flags[k*NUM_EXC+b];
		end
		assign merged[b] = |column;
	end
endmodule
`default_nettype wire

// >>> verilog/vector_fp_csr_unit.sv
// vector floating-point control/status unit with its data registers
// assumes an AXI4-Lite master, an execution stage that reports one op per
// pulse of op_valid, and a legacy stack unit that reports its own error level
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module vector_fp_csr_unit
	import vfp_pkg::*;
#(
	parameter bit DENORM_ZERO_SUPPORTED = 1'b1,
	parameter bit VEC1_SUPPORTED = 1'b1,
	parameter bit VEC2_SUPPORTED = 1'b1,
	parameter bit SAVE_SUPPORTED = 1'b1
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic soft_init_in,
	input wire logic [vfp_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [vfp_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic op_valid,
	input wire logic op_supported,
	input wire logic [vfp_pkg::NUM_LANES*vfp_pkg::NUM_EXC-1:0] op_lane_flags,
	output logic vector_fp_fault,
	output logic invalid_opcode_fault,
	output logic general_protection_fault,
	output logic [1:0] rounding_mode,
	output logic flush_zero_mode,
	output logic denormals_zero_mode,
	input wire logic legacy_error_pending_in,
	input wire logic ignore_numeric_error_in,
	output logic fp_error_out,
	input wire logic vreg_wr_en,
	input wire logic [vfp_pkg::VREG_IDX_W-1:0] vreg_wr_idx,
	input wire logic [vfp_pkg::VREG_W-1:0] vreg_wr_data,
	input wire logic [vfp_pkg::VREG_IDX_W-1:0] vreg_rd_idx,
	output logic [vfp_pkg::VREG_W-1:0] vreg_rd_data
);
	import vfp_pkg::*;

	bus_state_e wstate;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_fire;
	logic [31:0] csr;
	logic [31:0] writable_mask;
	logic [31:0] saved_mask;
	logic [31:0] identify_word;
	logic [31:0] sys_ctrl;
	logic [2:0] fault_status;
	logic [31:0] next_csr_write;
	logic csr_wr_ok;
	logic csr_wr_bad;
	logic flt_wr;
	logic [NUM_EXC-1:0] merged;
	logic [NUM_EXC-1:0] unmasked;
	logic op_exec;
	logic raise_vec;
	logic raise_opc;

	// ----------------------------------------
	// vector data registers and lane merge
	// ----------------------------------------
	vreg_if vregs ();

	assign vregs.wr_en = vreg_wr_en;
	assign vregs.wr_idx = vreg_wr_idx;
	assign vregs.wr_data = vreg_wr_data;
	assign vregs.rd_idx = vreg_rd_idx;
	assign vreg_rd_data = vregs.rd_data;

	vector_register_file u_vregs (
		.clock(clock),
		.rst_n(rst_n),
		.port(vregs.regfile)
	);

	lane_flag_merge u_merge (
		.lane_flags(op_lane_flags),
		.merged(merged)
	);

	// ----------------------------------------
	// capability words
	// ----------------------------------------
	assign writable_mask = DENORM_ZERO_SUPPORTED ? CSR_MASK_FULL : CSR_MASK_DEFAULT;
	assign saved_mask = DENORM_ZERO_SUPPORTED ? CSR_MASK_FULL : SAVED_MASK_NONE;

	always_comb begin
		identify_word = '0;
		identify_word[ID_SAVE_BIT] = SAVE_SUPPORTED;
		identify_word[ID_VEC1_BIT] = VEC1_SUPPORTED;
		identify_word[ID_VEC2_BIT] = VEC2_SUPPORTED;
	end

	// ----------------------------------------
	// write channel: address and data in either order
	// ----------------------------------------
	assign s_axi_awready = (wstate == BUS_IDLE) || (wstate == BUS_DATA);
	assign s_axi_wready = (wstate == BUS_IDLE) || (wstate == BUS_ADDR);
	assign s_axi_bvalid = (wstate == BUS_RESP);
	assign wr_fire = (wstate == BUS_EXEC);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wstate <= BUS_IDLE;
		end else begin
			case (wstate)
				BUS_IDLE: begin
					if (s_axi_awvalid && s_axi_wvalid) begin
						wstate <= BUS_EXEC;
					end else if (s_axi_awvalid) begin
						wstate <= BUS_ADDR;
					end else if (s_axi_wvalid) begin
						wstate <= BUS_DATA;
					end
				end
				BUS_ADDR: begin
					if (s_axi_wvalid) begin
						wstate <= BUS_EXEC;
					end
				end
				BUS_DATA: begin
					if (s_axi_awvalid) begin
						wstate <= BUS_EXEC;
					end
				end
				BUS_EXEC: begin
					wstate <= BUS_RESP;
				end
				BUS_RESP: begin
					if (s_axi_bready) begin
						wstate <= BUS_IDLE;
					end
				end
				default: begin
					wstate <= BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
		end
	end

	// byte-lane merge of the pending write onto the current value
	always_comb begin
		next_csr_write = csr;
		for (int b = 0; b < 4; b++) begin
			if (wr_strb[b]) begin
				next_csr_write[b*8 +: 8] = wr_data[b*8 +: 8];
			end
		end
	end

	assign csr_wr_bad = wr_fire && wr_addr == OFS_CSR
		&& |(next_csr_write & ~writable_mask);
	assign csr_wr_ok = wr_fire && wr_addr == OFS_CSR && !csr_wr_bad;
	assign flt_wr = wr_fire && wr_addr == OFS_FAULT && wr_strb[0];

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			if (csr_wr_bad) begin
				s_axi_bresp <= RESP_SLVERR;
			end else if (wr_addr == OFS_CSR || wr_addr == OFS_SYS_CTRL
				|| wr_addr == OFS_FAULT) begin
				s_axi_bresp <= RESP_OKAY;
			end else begin
				s_axi_bresp <= RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			if (s_axi_araddr == OFS_CSR) begin
				s_axi_rdata <= csr;
			end else if (s_axi_araddr == OFS_SAVED_MASK) begin
				s_axi_rdata <= saved_mask;
			end else if (s_axi_araddr == OFS_SYS_CTRL) begin
				s_axi_rdata <= sys_ctrl;
			end else if (s_axi_araddr == OFS_IDENTIFY) begin
				s_axi_rdata <= identify_word;
			end else if (s_axi_araddr == OFS_FAULT) begin
				s_axi_rdata <= {29'h0000_0000, fault_status};
			end else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// system control: os support and native error enable (set blocks the legacy error pin)
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sys_ctrl <= '0;
		end else if (wr_fire && wr_addr == OFS_SYS_CTRL) begin
			sys_ctrl <= '0;
			sys_ctrl[ERR_ENABLE_BIT] <= wr_data[ERR_ENABLE_BIT];
			sys_ctrl[OS_SAVE_BIT] <= wr_data[OS_SAVE_BIT];
			sys_ctrl[OS_SIMD_BIT] <= wr_data[OS_SIMD_BIT];
		end
	end

	// ----------------------------------------
	// exception detection for one vector op
	// ----------------------------------------
	assign op_exec = op_valid && op_supported;
	// only the new conditions of this op can fault, never old flags
	assign unmasked = merged & ~csr[MASK_LSB +: NUM_EXC];
	assign raise_vec = op_exec && |unmasked && sys_ctrl[OS_SIMD_BIT];
	assign raise_opc = (op_valid && !op_supported)
		|| (op_exec && |unmasked && !sys_ctrl[OS_SIMD_BIT]);

	// ----------------------------------------
	// control/status register
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			csr <= CSR_RESET;
		end else begin
			// soft init is deliberately absent here
			if (csr_wr_ok) begin
				csr <= next_csr_write | {26'h000_0000, op_exec ? merged : 6'h00};
			end else if (op_exec) begin
				csr[FLAG_LSB +: NUM_EXC] <= csr[FLAG_LSB +: NUM_EXC] | merged;
			end
		end
	end

	assign rounding_mode = csr[ROUND_LSB +: 2];
	assign flush_zero_mode = csr[FTZ_BIT];
	assign denormals_zero_mode = csr[DENORM_ZERO_BIT];

	// ----------------------------------------
	// fault pulses and sticky fault status
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			vector_fp_fault <= 1'b0;
			invalid_opcode_fault <= 1'b0;
			general_protection_fault <= 1'b0;
		end else begin
			vector_fp_fault <= raise_vec;
			invalid_opcode_fault <= raise_opc;
			general_protection_fault <= csr_wr_bad;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n || soft_init_in) begin
			fault_status <= '0;
		end else begin
			fault_status[FLT_VEC_BIT] <= raise_vec
				|| (fault_status[FLT_VEC_BIT] && !(flt_wr && wr_data[FLT_VEC_BIT]));
			fault_status[FLT_OPCODE_BIT] <= raise_opc
				|| (fault_status[FLT_OPCODE_BIT] && !(flt_wr && wr_data[FLT_OPCODE_BIT]));
			fault_status[FLT_PROT_BIT] <= csr_wr_bad
				|| (fault_status[FLT_PROT_BIT] && !(flt_wr && wr_data[FLT_PROT_BIT]));
		end
	end

	// ----------------------------------------
	// legacy unit error pin, fed only by the legacy unit
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fp_error_out <= 1'b0;
		end else begin
			fp_error_out <= legacy_error_pending_in && !sys_ctrl[ERR_ENABLE_BIT]
				&& !ignore_numeric_error_in;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_both_offered;
		wstate == BUS_IDLE && s_axi_awvalid && s_axi_wvalid;
	endsequence
	sequence s_answer;
		##1 wr_fire ##1 s_axi_bvalid;
	endsequence

	property p_reset_state;
		disable iff (1'b0) !rst_n |=> csr == CSR_RESET && vregs.rd_data == '0;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("bad reset state");
	property p_no_vector_fp_error_out;
		!legacy_error_pending_in |=> !fp_error_out;
	endproperty
	a_no_vector_fp_error_out: assert property (p_no_vector_fp_error_out) else $error("fp_error_out from vector");
	property p_ignore_pin;
		$changed(ignore_numeric_error_in) && !op_exec && !csr_wr_ok |=> $stable(csr);
	endproperty
	a_ignore_pin: assert property (p_ignore_pin) else $error("csr moved on pin");
	property p_flags_or;
		op_exec && !csr_wr_ok |=> (csr[5:0] & $past(merged)) == $past(merged);
	endproperty
	a_flags_or: assert property (p_flags_or) else $error("flag not set");
	property p_sticky;
		!csr_wr_ok |=> ($past(csr[5:0]) & ~csr[5:0]) == 6'h00;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped");
	property p_fault_route;
		op_exec && |unmasked |=> (vector_fp_fault == $past(sys_ctrl[OS_SIMD_BIT]))
			&& (invalid_opcode_fault != vector_fp_fault);
	endproperty
	a_fault_route: assert property (p_fault_route) else $error("wrong fault kind");
	property p_no_stale_fault;
		!(op_exec && |unmasked) |=> !vector_fp_fault;
	endproperty
	a_no_stale_fault: assert property (p_no_stale_fault) else $error("stale fault");
	property p_unsupported;
		op_valid && !op_supported |=> invalid_opcode_fault && !vector_fp_fault;
	endproperty
	a_unsupported: assert property (p_unsupported) else $error("no invalid opcode");
	property p_reserved_write;
		csr_wr_bad |=> general_protection_fault ##1 s_axi_bresp == RESP_SLVERR;
	endproperty
	a_reserved_write: assert property (p_reserved_write) else $error("no protection fault");
	property p_soft_init;
		soft_init_in && !op_exec && !csr_wr_ok |=> $stable(csr);
	endproperty
	a_soft_init: assert property (p_soft_init) else $error("init changed csr");
	property p_write_answer;
		s_both_offered |-> s_answer;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("late write answer");
endmodule
`default_nettype wire

// >>> verilog/vector_register_file.sv
// eight 128-bit vector data registers with one write and one read port
// assumes the top drives the channel synchronously; reads return next cycle
`timescale 1ns/1ps
`default_nettype none
module vector_register_file
	import vfp_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	vreg_if.regfile port
);
	logic [VREG_W-1:0] regs [NUM_VREGS];

	// ----------------------------------------
	// storage, cleared by hardware reset only
	// ----------------------------------------
	for (genvar i = 0; i < NUM_VREGS; i++) begin : g_entry
		always_ff @(posedge clock) begin
			if (!rst_n) begin
				regs[i] <= '0;
			end else if (port.wr_en && port.wr_idx == VREG_IDX_W'(i)) begin
				regs[i] <= port.wr_data;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			port.rd_data <= '0;
		end else begin
			port.rd_data <= regs[port.rd_idx];
		end
	end
endmodule
`default_nettype wire

// >>> verilog/vfp_pkg.sv
// constants shared by the vector floating-point control/status unit
// assumes a single 250 MHz core clock and a synchronous active-low reset
package vfp_pkg;

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int NUM_EXC = 6;
	localparam int NUM_LANES = 4;
	localparam int NUM_VREGS = 8;
	localparam int VREG_W = 128;
	localparam int VREG_IDX_W = 3;
	localparam int ADDR_W = 8;

	// ----------------------------------------
	// control/status register layout and reset
	// ----------------------------------------
	localparam int FLAG_LSB = 0;
	localparam int DENORM_ZERO_BIT = 6;
	localparam int MASK_LSB = 7;
	localparam int ROUND_LSB = 13;
	localparam int FTZ_BIT = 15;
	localparam logic [31:0] CSR_RESET = 32'h0000_1F80;
	localparam logic [31:0] CSR_MASK_DEFAULT = 32'h0000_FFBF;
	localparam logic [31:0] CSR_MASK_FULL = 32'h0000_FFFF;
	localparam logic [31:0] SAVED_MASK_NONE = 32'h0000_0000;

	// ----------------------------------------
	// system control, identify and fault status bits
	// ----------------------------------------
	localparam int ERR_ENABLE_BIT = 5;
	localparam int OS_SAVE_BIT = 9;
	localparam int OS_SIMD_BIT = 10;
	localparam int ID_SAVE_BIT = 24;
	localparam int ID_VEC1_BIT = 25;
	localparam int ID_VEC2_BIT = 26;
	localparam int FLT_VEC_BIT = 0;
	localparam int FLT_OPCODE_BIT = 1;
	localparam int FLT_PROT_BIT = 2;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CSR = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SAVED_MASK = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SYS_CTRL = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IDENTIFY = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_FAULT = 8'h10;

	// ----------------------------------------
	// bus answers and write-channel states
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b000,
		BUS_ADDR = 3'b001,
		BUS_DATA = 3'b010,
		BUS_EXEC = 3'b011,
		BUS_RESP = 3'b100
	} bus_state_e;

endpackage

// >>> verilog/vreg_if.sv
// access channel of the vector data register file
// assumes one writer and one reader on the core clock
`timescale 1ns/1ps
`default_nettype none
interface vreg_if import vfp_pkg::*; ();
	logic wr_en;
	logic [VREG_IDX_W-1:0] wr_idx;
	logic [VREG_W-1:0] wr_data;
	logic [VREG_IDX_W-1:0] rd_idx;
	logic [VREG_W-1:0] rd_data;

	modport regfile (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
	modport user (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
endinterface
`default_nettype wire
